// file: inc/dmf_pkg.sv
// shared constants and types of the dual-port mailbox block
package dmf_pkg;

   // ****************************************
   // host side byte offsets (AXI4-Lite)
   // ****************************************
   localparam logic [5:0] OFS_OUT_BASE = 6'h00;
   localparam logic [5:0] OFS_IN_BASE = 6'h10;
   localparam logic [5:0] OFS_STATUS = 6'h20;
   localparam logic [5:0] OFS_INTCTL = 6'h24;
   localparam logic [5:0] OFS_CTRL = 6'h28;

   // ****************************************
   // local side word indexes
   // ****************************************
   localparam logic [3:0] LOC_OUT_BASE = 4'h0;
   localparam logic [3:0] LOC_IN_BASE = 4'h4;
   localparam logic [3:0] LOC_STATUS = 4'h8;
   localparam logic [3:0] LOC_INTCTL = 4'h9;
   localparam logic [3:0] LOC_CTRL = 4'hA;

   // ****************************************
   // field positions
   // ****************************************
   localparam int ICFG_IN_EN = 0;
   localparam int ICFG_IN_MBX = 1;
   localparam int ICFG_IN_BYTE = 3;
   localparam int ICFG_OUT_EN = 8;
   localparam int ICFG_OUT_MBX = 9;
   localparam int ICFG_OUT_BYTE = 11;
   localparam int ICFG_IN_INT = 16;
   localparam int ICFG_OUT_INT = 17;
   localparam int CTRL_FLAG_RST = 0;

   // ****************************************
   // reset values and answers
   // ****************************************
   localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic en;
      logic [1:0] mbx;
      logic [1:0] bsel;
   } dmf_isrc_t;

   typedef struct packed {
      dmf_isrc_t in_src;
      dmf_isrc_t out_src;
      logic in_int;
      logic out_int;
   } dmf_ictl_t;

   localparam dmf_ictl_t ICTL_RST = '0;

   typedef struct packed {
      logic sel;
      logic wr;
      logic [3:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } dmf_lreq_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_FETCH = 2'b01,
      RD_RESP = 2'b10
   } dmf_rd_st_t;

endpackage : dmf_pkg

// file: design/dmf_mailbox_ram.sv
// eight-word mailbox storage with byte-wise writes and registered reads
`timescale 1ns/1ns
module dmf_mailbox_ram
   import dmf_pkg::*;
(
   // clock
   input wire logic aclk,
   // host port
   input wire logic h_we,
   input wire logic [2:0] h_waddr,
   input wire logic [3:0] h_be,
   input wire logic [31:0] h_wdata,
   input wire logic [2:0] h_raddr,
   output logic [31:0] h_rdata,
   // local port
   input wire logic l_we,
   input wire logic [2:0] l_waddr,
   input wire logic [3:0] l_be,
   input wire logic [31:0] l_wdata,
   input wire logic [2:0] l_raddr,
   output logic [31:0] l_rdata
);

   logic [31:0] mem [8];

   // reads sample the old word, so a write in the same cycle cannot tear it
   always_ff @(posedge aclk) begin
      h_rdata <= mem[h_raddr];
      l_rdata <= mem[l_raddr];
   end

   always_ff @(posedge aclk) begin
      for (int b = 0; b < 4; b++) begin
         if (h_we && h_be[b]) begin
            mem[h_waddr][8*b +: 8] <= h_wdata[8*b +: 8];
         end
         if (l_we && l_be[b]) begin
            mem[l_waddr][8*b +: 8] <= l_wdata[8*b +: 8];
         end
      end
   end

endmodule : dmf_mailbox_ram

// file: design/dmf_mailbox.sv
// dual-port mailbox with shared byte flags, host over AXI4-Lite
`timescale 1ns/1ns
// Function
// RULE1 - eight 32-bit mailboxes, four each way
// RULE2 - outgoing of one side is other's incoming
// RULE3 - each side has its own status register
// RULE4 - one outgoing, one incoming interrupt source per side
// RULE5 - local incoming reads go through holding register
// RULE6 - host incoming reads are interlocked against writes
// RULE7 - write sets flags only for enabled bytes
// RULE8 - write visible to peer, sets both flags
// RULE9 - incoming read clears flags of bytes read
// RULE10 - four status bits per mailbox, byte order
// RULE11 - flag clears only by read or global
// RULE12 - status registers are read-only
// RULE13 - control bit per side clears all flags
// RULE14 - both sides see identical flag values
// RULE15 - overwrite when full, stale read when empty
// RULE16 - only single transfers, no bursts
// RULE17 - host interrupt on edge after local access
// RULE18 - local interrupt one period later, clears immediately; code sets it at the same edge as its sticky bit, with no extra period
// RULE19 - reset leaves every mailbox byte empty
// RULE20 - local logic runs on this same clock
module dmf_mailbox
   import dmf_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // host register bus, write
   input wire logic [5:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // host register bus, read
   input wire logic [5:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // local side port, same clock
   input wire dmf_lreq_t local_req,
   output logic [31:0] local_rdata,
   output logic local_rvalid,
   // interrupts
   output logic host_irq,
   output logic local_irq
);

   // ****************************************
   // declarations
   // ****************************************
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic aw_full_r, w_full_r;
   logic [5:0] aw_addr_r, rd_addr_r;
   logic [31:0] w_data_r, rdata_r;
   logic [3:0] w_strb_r;
   logic [1:0] bresp_r, rresp_r;
   dmf_rd_st_t rd_st_r;
   logic wr_go, ar_hs;
   logic [3:0] wr_idx;
   logic [31:0] flags_r, flags_nxt, flag_set, flag_clr;
   logic gclr;
   logic l_wr, l_rd;
   logic lrd_r;
   logic [3:0] lrd_addr_r;
   logic [31:0] lrdata_r;
   logic lrvalid_r;
   logic [31:0] ram_h, ram_l;
   dmf_ictl_t ictl_r [2];
   logic [1:0] irq_r;
   logic [1:0] ictl_we;
   logic [31:0] ictl_wd [2];

   function automatic logic [31:0] ictl_word(input dmf_ictl_t c);
      logic [31:0] w;
      w = '0;
      w[ICFG_IN_EN] = c.in_src.en;
      w[ICFG_IN_MBX +: 2] = c.in_src.mbx;
      w[ICFG_IN_BYTE +: 2] = c.in_src.bsel;
      w[ICFG_OUT_EN] = c.out_src.en;
      w[ICFG_OUT_MBX +: 2] = c.out_src.mbx;
      w[ICFG_OUT_BYTE +: 2] = c.out_src.bsel;
      w[ICFG_IN_INT] = c.in_int;
      w[ICFG_OUT_INT] = c.out_int;
      return w;
   endfunction : ictl_word

   // ****************************************
   // host write channel
   // ****************************************
   // one write at a time; AXI4-Lite carries no bursts at all [RULE16]
   assign wr_go = aw_full_r && w_full_r && !bvalid_r;
   assign wr_idx = aw_addr_r[5:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            aw_full_r <= 1'b1;
            awready_r <= 1'b0;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            w_full_r <= 1'b1;
            wready_r <= 1'b0;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b1;
            // status and incoming words ignore writes but answer okay [RULE12]
            bresp_r <= (wr_idx > OFS_CTRL[5:2]) ? RESP_SLVERR : RESP_OKAY;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // host read channel
   // ****************************************
   assign ar_hs = s_axi_arvalid && arready_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st_r <= RD_IDLE;
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
         rd_addr_r <= '0;
      end else begin
         case (rd_st_r)
            RD_IDLE: begin
               if (ar_hs) begin
                  arready_r <= 1'b0;
                  rd_addr_r <= s_axi_araddr;
                  rd_st_r <= RD_FETCH;
               end
            end
            RD_FETCH: begin
               rvalid_r <= 1'b1;
               rresp_r <= RESP_OKAY;
               rd_st_r <= RD_RESP;
               // mailbox words come from the snapshot taken at the handshake [RULE6]
               if (rd_addr_r[5] == 1'b0) begin
                  rdata_r <= ram_h;
               end else if (rd_addr_r[5:2] == OFS_STATUS[5:2]) begin
                  rdata_r <= flags_r; // [RULE3]
               end else if (rd_addr_r[5:2] == OFS_INTCTL[5:2]) begin
                  rdata_r <= ictl_word(ictl_r[0]);
               end else if (rd_addr_r[5:2] == OFS_CTRL[5:2]) begin
                  rdata_r <= '0;
               end else begin
                  rdata_r <= '0;
                  rresp_r <= RESP_SLVERR;
               end
            end
            RD_RESP: begin
               if (s_axi_rready) begin
                  rvalid_r <= 1'b0;
                  arready_r <= 1'b1;
                  rd_st_r <= RD_IDLE;
               end
            end
            default: begin
               rd_st_r <= RD_IDLE;
               arready_r <= 1'b1;
               rvalid_r <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // shared mailbox storage
   // ****************************************
   // words 0..3 run host to local, words 4..7 local to host [RULE1] [RULE2]
   assign l_wr = local_req.sel && local_req.wr;
   assign l_rd = local_req.sel && !local_req.wr;

   dmf_mailbox_ram u_ram (
      .aclk(aclk),
      .h_we(wr_go && aw_addr_r[5:4] == OFS_OUT_BASE[5:4]), // [RULE8] [RULE15]
      .h_waddr({1'b0, aw_addr_r[3:2]}),
      .h_be(w_strb_r),
      .h_wdata(w_data_r),
      .h_raddr(s_axi_araddr[4:2]),
      .h_rdata(ram_h),
      .l_we(l_wr && local_req.addr[3:2] == LOC_OUT_BASE[3:2]),
      .l_waddr({1'b1, local_req.addr[1:0]}),
      .l_be(local_req.be),
      .l_wdata(local_req.wdata),
      .l_raddr({~local_req.addr[2], local_req.addr[1:0]}),
      .l_rdata(ram_l)
   );

   // ****************************************
   // byte flags
   // ****************************************
   // bits 4k..4k+3 are host-to-local box k, bits 16+4k.. local-to-host [RULE10]
   always_comb begin
      flag_set = '0;
      flag_clr = '0;
      gclr = 1'b0;
      if (wr_go && aw_addr_r[5:4] == OFS_OUT_BASE[5:4]) begin
         flag_set[{1'b0, aw_addr_r[3:2], 2'b00} +: 4] = w_strb_r; // [RULE7]
      end
      if (l_wr && local_req.addr[3:2] == LOC_OUT_BASE[3:2]) begin
         flag_set[{1'b1, local_req.addr[1:0], 2'b00} +: 4] = local_req.be; // [RULE7]
      end
      // the host bus has no read strobes, so a host read empties the whole word
      if (ar_hs && s_axi_araddr[5:4] == OFS_IN_BASE[5:4]) begin
         flag_clr[{1'b1, s_axi_araddr[3:2], 2'b00} +: 4] = 4'hF; // [RULE9]
      end
      if (l_rd && local_req.addr[3:2] == LOC_IN_BASE[3:2]) begin
         flag_clr[{1'b0, local_req.addr[1:0], 2'b00} +: 4] = local_req.be; // [RULE9]
      end
      if (wr_go && wr_idx == OFS_CTRL[5:2] && w_strb_r[0] && w_data_r[CTRL_FLAG_RST]) begin
         gclr = 1'b1; // [RULE13]
      end
      if (l_wr && local_req.addr == LOC_CTRL && local_req.be[0]
          && local_req.wdata[CTRL_FLAG_RST]) begin
         gclr = 1'b1; // [RULE13]
      end
      // a new write wins over any clear in the same cycle [RULE11]
      flags_nxt = ((flags_r & ~flag_clr) & {32{~gclr}}) | flag_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_r <= FLAGS_RST; // [RULE19]
      end else begin
         flags_r <= flags_nxt; // [RULE14]
      end
   end

   // ****************************************
   // local read pipeline
   // ****************************************
   // the storage holds its read word one cycle, so host writes cannot tear it [RULE5]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lrd_r <= 1'b0;
         lrd_addr_r <= '0;
         lrvalid_r <= 1'b0;
         lrdata_r <= '0;
      end else begin
         lrd_r <= l_rd; // [RULE20]
         lrd_addr_r <= local_req.addr;
         lrvalid_r <= lrd_r;
         if (lrd_r) begin
            if (lrd_addr_r[3] == 1'b0) begin
               lrdata_r <= ram_l;
            end else if (lrd_addr_r == LOC_STATUS) begin
               lrdata_r <= flags_r; // [RULE3]
            end else if (lrd_addr_r == LOC_INTCTL) begin
               lrdata_r <= ictl_word(ictl_r[1]);
            end else begin
               lrdata_r <= '0;
            end
         end
      end
   end

   // ****************************************
   // mailbox interrupts
   // ****************************************
   assign ictl_we[0] = wr_go && wr_idx == OFS_INTCTL[5:2];
   assign ictl_we[1] = l_wr && local_req.addr == LOC_INTCTL;
   assign ictl_wd[0] = w_data_r;
   assign ictl_wd[1] = local_req.wdata;

   // side 0 is the host, side 1 the local side; each watches the peer's traffic
   for (genvar s = 0; s < 2; s++) begin : g_int
      localparam logic IN_HI = (s == 0);
      logic [4:0] in_idx, out_idx;
      logic in_rise, out_fall;
      dmf_ictl_t nxt;

      // one incoming and one outgoing byte per side [RULE4]
      assign in_idx = {IN_HI, ictl_r[s].in_src.mbx, ictl_r[s].in_src.bsel};
      assign out_idx = {~IN_HI, ictl_r[s].out_src.mbx, ictl_r[s].out_src.bsel};
      assign in_rise = ictl_r[s].in_src.en && !flags_r[in_idx] && flags_nxt[in_idx];
      assign out_fall = ictl_r[s].out_src.en && flags_r[out_idx] && !flags_nxt[out_idx]
                        && !gclr;

      always_comb begin
         nxt = ictl_r[s];
         if (ictl_we[s]) begin
            nxt.in_src.en = ictl_wd[s][ICFG_IN_EN];
            nxt.in_src.mbx = ictl_wd[s][ICFG_IN_MBX +: 2];
            nxt.in_src.bsel = ictl_wd[s][ICFG_IN_BYTE +: 2];
            nxt.out_src.en = ictl_wd[s][ICFG_OUT_EN];
            nxt.out_src.mbx = ictl_wd[s][ICFG_OUT_MBX +: 2];
            nxt.out_src.bsel = ictl_wd[s][ICFG_OUT_BYTE +: 2];
            if (ictl_wd[s][ICFG_IN_INT]) begin
               nxt.in_int = 1'b0;
            end
            if (ictl_wd[s][ICFG_OUT_INT]) begin
               nxt.out_int = 1'b0;
            end
         end
         // an event in the clearing cycle is kept
         if (in_rise) begin
            nxt.in_int = 1'b1;
         end
         if (out_fall) begin
            nxt.out_int = 1'b1;
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            ictl_r[s] <= ICTL_RST;
            irq_r[s] <= 1'b0;
         end else begin
            ictl_r[s] <= nxt;
            // follows the sticky bits at the same edge, set and clear alike [RULE17] [RULE18]
            irq_r[s] <= nxt.in_int || nxt.out_int;
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign local_rdata = lrdata_r;
   assign local_rvalid = lrvalid_r;
   assign host_irq = irq_r[0];
   assign local_irq = irq_r[1];

endmodule : dmf_mailbox

// file: test/dmf_local_model.sv
// local add-on side model driving the local port
`timescale 1ns/1ns
module dmf_local_model
   import dmf_pkg::*;
(
   // clock
   input wire logic aclk,
   // local port
   output dmf_lreq_t local_req,
   input wire logic [31:0] local_rdata,
   input wire logic local_rvalid
);
   initial local_req = '0;
   // strobes launch off aclk itself, there is no synchroniser
   task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] dv);
      @(posedge aclk);
      local_req <= '{sel: 1'h1, wr: 1'h1, addr: a, be: be, wdata: dv};
      @(posedge aclk);
      // idle lines flip so a stale value is never mistaken for live data
      local_req <= '{sel: 1'h0, wr: 1'h0, addr: ~a, be: ~be, wdata: ~dv};
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [3:0] be, output logic [31:0] dv);
      @(posedge aclk);
      local_req <= '{sel: 1'h1, wr: 1'h0, addr: a, be: be, wdata: ~local_req.wdata};
      @(posedge aclk);
      local_req.sel <= 1'h0;
      do @(posedge aclk); while (local_rvalid !== 1'h1);
      dv = local_rdata;
   endtask : rd
endmodule : dmf_local_model

// file: test/dmf_mailbox_asserts.sv
// port-level timing checks of the mailbox block
`timescale 1ns/1ns
module dmf_mailbox_asserts
   import dmf_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // host bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // local side and interrupts
   input wire dmf_lreq_t local_req,
   input wire logic local_rvalid,
   input wire logic host_irq,
   input wire logic local_irq
);
   // ****
   // sequences and properties
   // ****
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_loc_rd;
      local_req.sel && !local_req.wr;
   endsequence
   a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write answer not two cycles after take");
   a_wr_single: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
      else $error("second write accepted while one is open");
   a_rd_answer: assert property (s_rd_take |=> !s_axi_rvalid ##1 s_axi_rvalid)
      else $error("read answer not two cycles after take");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_loc_answer: assert property (s_loc_rd |-> ##2 local_rvalid)
      else $error("local read answer late");
   a_host_irq_src: assert property ($rose(host_irq) |-> $past(local_req.sel))
      else $error("host interrupt without local access");
   a_loc_irq_src: assert property ($rose(local_irq) |->
      $rose(s_axi_bvalid) || $past(s_axi_arvalid && s_axi_arready))
      else $error("local interrupt without host access");
   a_reset_quiet: assert property ($rose(aresetn) |->
      !host_irq && !local_irq && !s_axi_bvalid && !local_rvalid)
      else $error("outputs busy after reset");
endmodule : dmf_mailbox_asserts
bind dmf_mailbox dmf_mailbox_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .local_req(local_req), .local_rvalid(local_rvalid), .host_irq(host_irq),
   .local_irq(local_irq));

// file: test/dmf_mailbox_tb.sv
// self-checking bench of the dual-port mailbox block
`timescale 1ns/1ns
module dmf_mailbox_tb
   import dmf_pkg::*;
;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [5:0] awa = '0, ara = '0;
   logic awv = '0, wv = '0, bry = '0, arv = '0, rry = '0;
   logic [31:0] wd = '0;
   logic [3:0] ws = '0;
   logic awr, wry, bv, arr, rv, hirq, lirq, lrv;
   logic [1:0] br, rr, r;
   logic [31:0] rd, lrd, d, got, flg = '0;
   logic [31:0] h2l [4];
   logic [3:0] s, b;
   dmf_lreq_t lreq;
   int num_errors = 0, n_compared = 0, k;
   dmf_mailbox u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wry), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .local_req(lreq), .local_rdata(lrd),
      .local_rvalid(lrv), .host_irq(hirq), .local_irq(lirq));
   dmf_local_model u_loc (.aclk(aclk), .local_req(lreq), .local_rdata(lrd),
      .local_rvalid(lrv));
   initial forever #25 aclk = ~aclk;
   // ****
   // bus tasks and checks
   // ****
   function automatic logic [31:0] bmask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : bmask
   task automatic axi_wr(input logic [5:0] a, input logic [31:0] dv, input logic [3:0] sv);
      @(posedge aclk);
      awa <= a;
      wd <= dv;
      ws <= sv;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'h0;
         if (wry) wv <= 1'h0;
      end while (bv !== 1'h1);
      r = br;
      bry <= 1'h0;
   endtask : axi_wr
   task automatic axi_rd(input logic [5:0] a, output logic [31:0] dv);
      @(posedge aclk);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'h0;
      end while (rv !== 1'h1);
      dv = rd;
      r = rr;
      rry <= 1'h0;
   endtask : axi_rd
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
         num_errors++;
      end
   endtask : chk
   task automatic chk_flags();
      logic [31:0] v;
      axi_rd(OFS_STATUS, v);
      chk(v, flg);
      u_loc.rd(LOC_STATUS, 4'hF, v);
      chk(v, flg);
   endtask : chk_flags
   task automatic chk_irq(input logic [1:0] e);
      @(posedge aclk);
      #1;
      chk({30'h0, hirq, lirq}, {30'h0, e});
   endtask : chk_irq
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   // ****
   // tests
   // ****
   initial begin
      // whole run is well under a thousand cycles
      repeat (6000) @(posedge aclk);
      num_errors++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      d = $urandom(20);
      chk_flags();
      $display("test reset done");
      for (k = 0; k < 4; k++) begin
         h2l[k] = $urandom;
         axi_wr(OFS_OUT_BASE + 6'(4 * k), h2l[k], 4'hF);
         d = $urandom;
         u_loc.wr(LOC_OUT_BASE + 4'(k), 4'hF, d);
         flg = flg | (32'h000F_000F << (4 * k));
         chk_flags();
         axi_rd(OFS_IN_BASE + 6'(4 * k), got);
         chk(got, d);
         flg[16 + 4 * k +: 4] = 4'h0;
         chk_flags();
      end
      $display("test all mailboxes done");
      repeat (12) begin
         k = $urandom % 4;
         s = 4'($urandom);
         d = $urandom;
         axi_wr(OFS_OUT_BASE + 6'(4 * k), d, s);
         h2l[k] = (h2l[k] & ~bmask(s)) | (d & bmask(s));
         flg[4 * k +: 4] = flg[4 * k +: 4] | s;
         chk_flags();
         b = 4'($urandom);
         u_loc.rd(LOC_IN_BASE + 4'(k), b, d);
         chk(d, h2l[k]);
         flg[4 * k +: 4] = flg[4 * k +: 4] & ~b;
         chk_flags();
      end
      $display("test random traffic done");
      axi_wr(OFS_CTRL, 32'h1, 4'hF);
      flg = '0;
      chk_flags();
      axi_wr(OFS_OUT_BASE + 6'h4, 32'h1234_5678, 4'h3);
      flg = 32'h0000_0030;
      chk_flags();
      axi_wr(OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      chk_flags();
      u_loc.wr(LOC_CTRL, 4'hF, 32'h1);
      flg = '0;
      chk_flags();
      axi_rd(6'h2C, d);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      $display("test flag control done");
      u_loc.wr(LOC_INTCTL, 4'hF, 32'h1);
      axi_wr(OFS_OUT_BASE, 32'hA5A5_A5A5, 4'h2);
      chk_irq(2'h0);
      axi_wr(OFS_OUT_BASE, 32'hA5A5_A5A5, 4'h1);
      chk_irq(2'h1);
      u_loc.wr(LOC_INTCTL, 4'hF, 32'h0001_0001);
      chk_irq(2'h0);
      axi_wr(OFS_INTCTL, 32'h0000_0100, 4'hF);
      u_loc.rd(LOC_IN_BASE, 4'h1, d);
      chk_irq(2'h2);
      axi_wr(OFS_INTCTL, 32'h0002_0001, 4'hF);
      chk_irq(2'h0);
      u_loc.wr(LOC_OUT_BASE, 4'h1, 32'h5A);
      chk_irq(2'h2);
      // local outgoing box 0 byte 0 empties on the host read; host sticky bit still set
      u_loc.wr(LOC_INTCTL, 4'hF, 32'h0000_0100);
      axi_rd(OFS_IN_BASE, d);
      chk_irq(2'h3);
      $display("test interrupts done");
      give_verdict();
   end
endmodule : dmf_mailbox_tb
